// [sfl_pkg.sv]
// Constants and types shared by the serial flash read and latch command front-end.
package sfl_pkg;
   localparam int NDIE = 2;
   localparam int SYNC_W = 10;
   // Synchroniser reset value: select reads as deselected, clock and lanes low.
   localparam logic [9:0] SYNC_RST = 10'h200;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST = 8'h0B;
   localparam logic [7:0] OP_DOUT = 8'h3B;
   localparam logic [7:0] OP_DIO = 8'hBB;
   localparam logic [7:0] OP_QOUT = 8'h6B;
   localparam logic [7:0] OP_QIO = 8'hEB;
   localparam logic [7:0] OP_DTR_FAST = 8'h0D;
   localparam logic [7:0] OP_DTR_DOUT = 8'h3D;
   localparam logic [7:0] OP_DTR_DIO = 8'hBD;
   localparam logic [7:0] OP_DTR_QOUT = 8'h6D;
   localparam logic [7:0] OP_DTR_QIO = 8'hED;
   localparam logic [7:0] OP_QWORD = 8'hE7;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_CLRFLG = 8'h50;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_RDFSR = 8'h70;
   localparam logic [7:0] OP_RDNV = 8'hB5;
   localparam logic [7:0] OP_RDVC = 8'h85;
   localparam logic [7:0] OP_RDEV = 8'h65;
   localparam logic [1:0] PROTO_EXT = 2'h0;
   localparam logic [1:0] PROTO_DUAL = 2'h1;
   localparam logic [1:0] PROTO_QUAD = 2'h2;
   localparam logic [2:0] W1 = 3'h1;
   localparam logic [2:0] W2 = 3'h2;
   localparam logic [2:0] W4 = 3'h4;
   localparam logic [3:0] QWORD_DUMMY = 4'h4;
   localparam logic [3:0] NO_DUMMY = 4'h0;
   localparam logic [4:0] CMD_BITS = 5'h08;
   localparam logic [4:0] ADDR_BITS = 5'h18;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [1:0] NV_BYTES = 2'h2;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_WAITDS, ST_IGNORE} sfl_state_t;
   typedef enum logic [2:0] {SRC_MEM, SRC_SR, SRC_FSR, SRC_NV, SRC_VC, SRC_EV} sfl_src_t;
endpackage

// [sfl_lane_if.sv]
// Per-die output control passed from the command engine to a lane driver.
`timescale 1ns/10ps
interface sfl_lane_if;
   logic adv;
   logic load;
   logic [7:0] byte_d;
   logic [2:0] wid;
   logic drive;
   modport ctl (output adv, output load, output byte_d, output wid, output drive);
   modport drv (input adv, input load, input byte_d, input wid, input drive);
endinterface

// [sfl_sync.sv]
// Two-flop synchroniser for select, serial clock and data lanes.
`timescale 1ns/10ps
module sfl_sync (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic [sfl_pkg::SYNC_W-1:0] d_i,
   output logic [sfl_pkg::SYNC_W-1:0] q_o
);
   generate
      for (genvar i = 0; i < sfl_pkg::SYNC_W; i++) begin : g_bit
         logic m_q;
         always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
               m_q <= sfl_pkg::SYNC_RST[i];
               q_o[i] <= sfl_pkg::SYNC_RST[i];
            end else if (ce_i) begin
               m_q <= d_i[i];
               q_o[i] <= m_q;
            end
         end
      end
   endgenerate
endmodule

// [sfl_lane_drv.sv]
// Output shifter for one die: places a byte on one, two or four of its lanes.
`timescale 1ns/10ps
module sfl_lane_drv (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   sfl_lane_if.drv lif,
   output logic [3:0] lane_o,
   output logic [3:0] oe_o
);
   logic [7:0] sh_q;
   logic [7:0] sh_d;
   logic [3:0] lane_d;
   logic [3:0] oe_d;
   logic [3:0] mask;

   assign sh_d = lif.load ? lif.byte_d : (lif.adv ? sh_q << lif.wid : sh_q);
   // Single-lane output leaves on lane 1 so that lane 0 stays an input.
   assign lane_d = (lif.wid == sfl_pkg::W1) ? {2'h0, sh_d[7], 1'b0} :
                   (lif.wid == sfl_pkg::W2) ? {2'h0, sh_d[7:6]} : sh_d[7:4];
   assign mask = (lif.wid == sfl_pkg::W1) ? 4'h2 : (lif.wid == sfl_pkg::W2) ? 4'h3 : 4'hF;
   assign oe_d = lif.drive ? mask : 4'h0;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         sh_q <= 8'h00;
         lane_o <= 4'h0;
         oe_o <= 4'h0;
      end else if (ce_i) begin
         sh_q <= sh_d;
         lane_o <= lane_d;
         oe_o <= oe_d;
      end
   end
endmodule

// [sfl_top.sv]
// Serial flash command front-end: array reads, write enable latch and register reads.
//
// What this block does
// [R1] Select low, opcode, address; deselect ends reads.
// [R2] Three address bytes, bits 23 to 0.
// [R3] First address bit sampled on rising clock.
// [R4] Start anywhere, address increments per byte.
// [R5] Past top address, wrap to zero.
// [R6] Decode single-rate array read opcodes.
// [R7] DTR opcodes always double rate.
// [R8] Word read: even address, four dummies.
// [R9] Word read ignored in dual and DTR.
// [R10] Host raises select after eighth bit.
// [R11] Late deselect discards latch commands.
// [R12] 06h sets latch, 04h clears it.
// [R13] Protection error keeps latch; clear-flag clears.
// [R14] Register reads use protocol lane sets.
// [R15] Status and flag status readable anytime.
// [R16] Nonvolatile read: 16 bits then zeros.
// [R17] Nonvolatile value least significant byte first.
// [R18] Volatile register reads repeat one byte.
// [R19] Fast read dummy count is configurable.
// [R20] Lanes driven only during data output.
// [R21] Both dice answer on own lanes.
`timescale 1ns/10ps
module sfl_top (
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   input wire logic CLK_EN_I,
   input wire logic SEL_B_I,
   input wire logic SCLK_I,
   input wire logic [7:0] LANE_I,
   output logic [7:0] LANE_O,
   output logic [7:0] LANE_OE_O,
   input wire logic [1:0] PROTO_I,
   input wire logic DTR_EN_I,
   input wire logic [3:0] DUMMY_CYC_I,
   input wire logic PROT_ERR_I,
   input wire logic [7:0] STATUS_I,
   input wire logic [7:0] FLAG_I,
   input wire logic [15:0] NVCFG_I,
   input wire logic [7:0] VCFG_I,
   input wire logic [7:0] EVCFG_I,
   output logic [23:0] MEM_ADDR_O,
   input wire logic [15:0] MEM_DATA_I,
   output logic WEL_O,
   output logic CLR_FLAG_O
);
   // ----------------------------------------
   // Pin synchronisation and edge detection
   // ----------------------------------------
   logic [sfl_pkg::SYNC_W-1:0] syn;
   logic sel_s;
   logic sclk_s;
   logic [7:0] lane_s;
   logic sclk_p_q;
   logic rise;
   logic fall;

   sfl_sync u_sync (
      .clk_i(SYS_CLK_I),
      .rst_b_i(RST_B_I),
      .ce_i(CLK_EN_I),
      .d_i({SEL_B_I, SCLK_I, LANE_I}),
      .q_o(syn)
   );

   assign sel_s = syn[9];
   assign sclk_s = syn[8];
   assign lane_s = syn[7:0];
   assign rise = sclk_s & ~sclk_p_q;
   assign fall = ~sclk_s & sclk_p_q;

   // ----------------------------------------
   // Engine state
   // ----------------------------------------
   sfl_pkg::sfl_state_t st_q, st_d;
   sfl_pkg::sfl_src_t src_q, src_d, src_nx;
   logic [4:0] cnt_q, cnt_d;
   logic [7:0] op_q, op_d, op_nx;
   logic [23:0] addr_q, addr_d, addr_nx, sh_nx;
   logic ddr_q, ddr_d;
   logic [2:0] awid_q, awid_d, dwid_q, dwid_d;
   logic [3:0] dum_q, dum_d, bcnt_q, bcnt_d;
   logic [1:0] nvix_q, nvix_d;
   logic drv_q, drv_d;
   logic wel_q, wel_d, clr_q;

   // Shifts one sample of the die-0 lanes into a word, lane 3 or 1 most significant.
   function automatic logic [23:0] shin(input logic [23:0] v, input logic [2:0] w, input logic [3:0] l);
      logic [23:0] r;
      r = {v[19:0], l};
      if (w == sfl_pkg::W1) begin
         r = {v[22:0], l[0]};
      end else if (w == sfl_pkg::W2) begin
         r = {v[21:0], l[1:0]};
      end
      return r;
   endfunction

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic ext;
   logic [2:0] pwid;
   logic smp;
   logic cmd_end;
   logic addr_end;
   logic op2a, op4a, op2d, op4d;
   logic rd_mem, rd_reg, wr_op, dtr_op, ign_qw;
   logic [2:0] aw_nx, dw_nx;
   logic [3:0] dm_nx;
   logic adv, load, drive, exec;
   logic [7:0] reg_b;

   assign ext = PROTO_I == sfl_pkg::PROTO_EXT;
   assign pwid = (PROTO_I == sfl_pkg::PROTO_QUAD) ? sfl_pkg::W4 :
                 (PROTO_I == sfl_pkg::PROTO_DUAL) ? sfl_pkg::W2 : sfl_pkg::W1;
   // Rising edges always sample; double rate adds falls, but never before the first address bit, which rises.
   assign smp = rise | (ddr_q & fall & ~((st_q == sfl_pkg::ST_ADDR) & (cnt_q == 5'h00))); // [R3]
   assign sh_nx = shin({16'h0000, op_q}, pwid, lane_s[3:0]);
   assign op_nx = sh_nx[7:0];
   assign addr_nx = shin(addr_q, awid_q, lane_s[3:0]); // [R2]
   assign cmd_end = (cnt_q + 5'(pwid)) == sfl_pkg::CMD_BITS;
   assign addr_end = (cnt_q + 5'(awid_q)) == sfl_pkg::ADDR_BITS; // [R2]

   assign rd_mem = op_nx inside {sfl_pkg::OP_READ, sfl_pkg::OP_FAST, sfl_pkg::OP_DOUT, sfl_pkg::OP_DIO,
                                 sfl_pkg::OP_QOUT, sfl_pkg::OP_QIO, sfl_pkg::OP_DTR_FAST,
                                 sfl_pkg::OP_DTR_DOUT, sfl_pkg::OP_DTR_DIO, sfl_pkg::OP_DTR_QOUT,
                                 sfl_pkg::OP_DTR_QIO, sfl_pkg::OP_QWORD}; // [R6]
   assign dtr_op = op_nx inside {sfl_pkg::OP_DTR_FAST, sfl_pkg::OP_DTR_DOUT, sfl_pkg::OP_DTR_DIO,
                                 sfl_pkg::OP_DTR_QOUT, sfl_pkg::OP_DTR_QIO}; // [R7]
   assign rd_reg = op_nx inside {sfl_pkg::OP_RDSR, sfl_pkg::OP_RDFSR, sfl_pkg::OP_RDNV,
                                 sfl_pkg::OP_RDVC, sfl_pkg::OP_RDEV};
   assign wr_op = op_nx inside {sfl_pkg::OP_WREN, sfl_pkg::OP_WRDI, sfl_pkg::OP_CLRFLG};
   // Word read has no double-rate form and is not decoded under the dual protocol.
   assign ign_qw = (op_nx == sfl_pkg::OP_QWORD) & ((PROTO_I == sfl_pkg::PROTO_DUAL) | DTR_EN_I); // [R9]

   assign op2a = op_nx inside {sfl_pkg::OP_DIO, sfl_pkg::OP_DTR_DIO};
   assign op4a = op_nx inside {sfl_pkg::OP_QIO, sfl_pkg::OP_DTR_QIO, sfl_pkg::OP_QWORD};
   assign op2d = op2a | (op_nx inside {sfl_pkg::OP_DOUT, sfl_pkg::OP_DTR_DOUT});
   assign op4d = op4a | (op_nx inside {sfl_pkg::OP_QOUT, sfl_pkg::OP_DTR_QOUT});
   assign aw_nx = !ext ? pwid : op4a ? sfl_pkg::W4 : op2a ? sfl_pkg::W2 : sfl_pkg::W1;
   assign dw_nx = !ext ? pwid : op4d ? sfl_pkg::W4 : op2d ? sfl_pkg::W2 : sfl_pkg::W1;
   assign dm_nx = (op_nx == sfl_pkg::OP_READ) ? sfl_pkg::NO_DUMMY :
                  (op_nx == sfl_pkg::OP_QWORD) ? sfl_pkg::QWORD_DUMMY : DUMMY_CYC_I; // [R8] [R19]
   assign src_nx = (op_nx == sfl_pkg::OP_RDSR) ? sfl_pkg::SRC_SR :
                   (op_nx == sfl_pkg::OP_RDFSR) ? sfl_pkg::SRC_FSR :
                   (op_nx == sfl_pkg::OP_RDNV) ? sfl_pkg::SRC_NV :
                   (op_nx == sfl_pkg::OP_RDVC) ? sfl_pkg::SRC_VC : sfl_pkg::SRC_EV;

   // ----------------------------------------
   // Data phase controls
   // ----------------------------------------
   // Output moves on the falling edge, and on both edges at double rate.
   assign adv = (st_q == sfl_pkg::ST_DATA) & ~sel_s & (fall | (ddr_q & rise));
   assign load = adv & (bcnt_q == sfl_pkg::BYTE_BITS);
   assign drive = (st_q == sfl_pkg::ST_DATA) & (drv_q | adv) & ~sel_s; // [R20]
   // A latch command only runs when select rises with nothing clocked past its opcode.
   assign exec = (st_q == sfl_pkg::ST_WAITDS) & sel_s; // [R11]
   // Status and flag status are sampled afresh for every byte, so they track a busy device.
   assign reg_b = (src_q == sfl_pkg::SRC_SR) ? STATUS_I :
                  (src_q == sfl_pkg::SRC_FSR) ? FLAG_I : // [R15]
                  (src_q == sfl_pkg::SRC_VC) ? VCFG_I :
                  (src_q == sfl_pkg::SRC_EV) ? EVCFG_I : // [R18]
                  (nvix_q == 2'h0) ? NVCFG_I[7:0] :
                  (nvix_q == 2'h1) ? NVCFG_I[15:8] : sfl_pkg::ZERO_BYTE; // [R16] [R17]

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      op_d = op_q;
      addr_d = addr_q;
      ddr_d = ddr_q;
      awid_d = awid_q;
      dwid_d = dwid_q;
      dum_d = dum_q;
      src_d = src_q;
      bcnt_d = bcnt_q;
      nvix_d = nvix_q;
      drv_d = drv_q;
      if (sel_s) begin
         st_d = sfl_pkg::ST_IDLE; // [R1]
         drv_d = 1'b0;
      end else begin
         unique case (st_q)
            sfl_pkg::ST_IDLE: begin
               st_d = sfl_pkg::ST_CMD;
               cnt_d = 5'h00;
               op_d = 8'h00;
               ddr_d = DTR_EN_I; // [R7]
            end
            sfl_pkg::ST_CMD: begin
               if (smp) begin
                  op_d = op_nx;
                  cnt_d = cnt_q + 5'(pwid);
               end
               if (smp && cmd_end) begin
                  bcnt_d = sfl_pkg::BYTE_BITS;
                  nvix_d = 2'h0;
                  if (rd_mem && !ign_qw) begin
                     st_d = sfl_pkg::ST_ADDR; // [R1]
                     cnt_d = 5'h00;
                     awid_d = aw_nx;
                     dwid_d = dw_nx;
                     dum_d = dm_nx;
                     ddr_d = DTR_EN_I | dtr_op; // [R7]
                     src_d = sfl_pkg::SRC_MEM;
                  end else if (rd_reg) begin
                     st_d = sfl_pkg::ST_DATA;
                     dwid_d = pwid; // [R14]
                     src_d = src_nx;
                  end else if (wr_op) begin
                     st_d = sfl_pkg::ST_WAITDS;
                  end else begin
                     st_d = sfl_pkg::ST_IGNORE; // [R9]
                  end
               end
            end
            sfl_pkg::ST_ADDR: begin
               if (smp) begin
                  addr_d = addr_nx; // [R3]
                  cnt_d = cnt_q + 5'(awid_q);
                  if (addr_end) begin
                     cnt_d = 5'h00;
                     st_d = (dum_q == sfl_pkg::NO_DUMMY) ? sfl_pkg::ST_DATA : sfl_pkg::ST_DUMMY;
                  end
               end
            end
            sfl_pkg::ST_DUMMY: begin
               // Dummies are counted in whole clocks, also at double rate.
               if (rise) begin
                  cnt_d = cnt_q + 5'h01;
                  if ((cnt_q + 5'h01) == {1'b0, dum_q}) begin
                     st_d = sfl_pkg::ST_DATA; // [R19]
                  end
               end
            end
            sfl_pkg::ST_DATA: begin
               if (adv) begin
                  drv_d = 1'b1; // [R20]
                  bcnt_d = load ? {1'b0, dwid_q} : bcnt_q + {1'b0, dwid_q};
               end
               if (load && src_q == sfl_pkg::SRC_MEM) begin
                  addr_d = addr_q + 24'h00_0001; // [R4] [R5]
               end
               if (load && src_q == sfl_pkg::SRC_NV && nvix_q != sfl_pkg::NV_BYTES) begin
                  nvix_d = nvix_q + 2'h1; // [R16]
               end
            end
            sfl_pkg::ST_WAITDS: begin
               if (smp) begin
                  st_d = sfl_pkg::ST_IGNORE; // [R11]
               end
            end
            sfl_pkg::ST_IGNORE: begin
               st_d = sfl_pkg::ST_IGNORE;
            end
         endcase
      end
   end

   // Write disable cannot drop the latch while a protection error stands.
   assign wel_d = (exec && op_q == sfl_pkg::OP_WREN) ? 1'b1 : // [R12]
                  (exec && op_q == sfl_pkg::OP_WRDI && !PROT_ERR_I) ? 1'b0 : // [R12] [R13]
                  (exec && op_q == sfl_pkg::OP_CLRFLG) ? 1'b0 : wel_q; // [R13]

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         st_q <= sfl_pkg::ST_IDLE;
         src_q <= sfl_pkg::SRC_MEM;
         cnt_q <= 5'h00;
         op_q <= 8'h00;
         addr_q <= 24'h00_0000;
         ddr_q <= 1'b0;
         awid_q <= sfl_pkg::W1;
         dwid_q <= sfl_pkg::W1;
         dum_q <= sfl_pkg::NO_DUMMY;
         bcnt_q <= sfl_pkg::BYTE_BITS;
         nvix_q <= 2'h0;
         drv_q <= 1'b0;
      end else if (CLK_EN_I) begin
         st_q <= st_d;
         src_q <= src_d;
         cnt_q <= cnt_d;
         op_q <= op_d;
         addr_q <= addr_d;
         ddr_q <= ddr_d;
         awid_q <= awid_d;
         dwid_q <= dwid_d;
         dum_q <= dum_d;
         bcnt_q <= bcnt_d;
         nvix_q <= nvix_d;
         drv_q <= drv_d;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         sclk_p_q <= 1'b0;
         wel_q <= 1'b0;
         clr_q <= 1'b0;
      end else if (CLK_EN_I) begin
         sclk_p_q <= sclk_s;
         wel_q <= wel_d;
         clr_q <= exec && op_q == sfl_pkg::OP_CLRFLG; // [R13]
      end
   end

   assign MEM_ADDR_O = addr_q;
   assign WEL_O = wel_q;
   assign CLR_FLAG_O = clr_q;

   // ----------------------------------------
   // Per-die lane drivers
   // ----------------------------------------
   // Both dice share one command engine; each returns its own array byte on its own lanes, and both return the same register byte.
   generate
      for (genvar d = 0; d < sfl_pkg::NDIE; d++) begin : g_die
         sfl_lane_if lif ();
         logic [7:0] mem_b;
         assign mem_b = MEM_DATA_I[8*d +: 8]; // [R21]
         assign lif.adv = adv;
         assign lif.load = load;
         assign lif.wid = dwid_q;
         assign lif.drive = drive;
         assign lif.byte_d = (src_q == sfl_pkg::SRC_MEM) ? mem_b : reg_b;
         sfl_lane_drv u_drv (
            .clk_i(SYS_CLK_I),
            .rst_b_i(RST_B_I),
            .ce_i(CLK_EN_I),
            .lif(lif),
            .lane_o(LANE_O[4*d +: 4]), // [R21]
            .oe_o(LANE_OE_O[4*d +: 4])
         );
      end
   endgenerate

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RST_B_I || !CLK_EN_I);

   a_desel_release: assert property (sel_s |-> ##[1:2] LANE_OE_O == 8'h00) // [R1]
      else $error("Lanes still driven after deselect.");
   a_quiet_phases: assert property ((st_q inside {sfl_pkg::ST_CMD, sfl_pkg::ST_ADDR,
      sfl_pkg::ST_DUMMY}) [*2] |-> LANE_OE_O == 8'h00) // [R20]
      else $error("Lanes driven before the data phase.");
   a_wel_set: assert property (exec && op_q == sfl_pkg::OP_WREN |=> WEL_O) // [R12]
      else $error("Write enable did not set the latch.");
   a_wel_clear: assert property (exec && op_q == sfl_pkg::OP_WRDI && !PROT_ERR_I |=> !WEL_O) // [R12]
      else $error("Write disable did not clear the latch.");
   a_wel_prot_hold: assert property (exec && op_q == sfl_pkg::OP_WRDI && PROT_ERR_I && WEL_O
      |=> WEL_O) // [R13]
      else $error("Write disable cleared the latch under a protection error.");
   a_discard_late: assert property (st_q == sfl_pkg::ST_IGNORE |=> $stable(WEL_O)) // [R11]
      else $error("Discarded command changed the latch.");
   a_addr_incr: assert property (load && src_q == sfl_pkg::SRC_MEM
      |=> MEM_ADDR_O == $past(MEM_ADDR_O) + 24'h00_0001) // [R4]
      else $error("Address did not advance after a byte.");
   a_addr_wrap: assert property (load && src_q == sfl_pkg::SRC_MEM && MEM_ADDR_O == 24'hFF_FFFF
      |=> MEM_ADDR_O == 24'h00_0000) // [R5]
      else $error("Address did not wrap to zero.");
   a_qword_dummy: assert property (st_q == sfl_pkg::ST_CMD && st_d == sfl_pkg::ST_ADDR
      && op_nx == sfl_pkg::OP_QWORD |=> dum_q == 4'h4) // [R8]
      else $error("Word read did not take four dummy clocks.");
   a_qword_dual: assert property (st_q == sfl_pkg::ST_CMD && !sel_s && smp && cmd_end
      && op_nx == sfl_pkg::OP_QWORD && PROTO_I == sfl_pkg::PROTO_DUAL |=> st_q == sfl_pkg::ST_IGNORE) // [R9]
      else $error("Word read was not ignored under the dual protocol.");
   a_dtr_force: assert property (st_q == sfl_pkg::ST_CMD && st_d == sfl_pkg::ST_ADDR && dtr_op
      |=> ddr_q ##1 (ddr_q || st_q == sfl_pkg::ST_IDLE)) // [R7]
      else $error("Double-rate opcode ran at single rate.");

   c_fast_read: cover property (st_q == sfl_pkg::ST_DATA && src_q == sfl_pkg::SRC_MEM && load);
   c_dtr_read: cover property (st_q == sfl_pkg::ST_DATA && ddr_q && load);
   c_wel_set: cover property (exec && op_q == sfl_pkg::OP_WREN);
   c_nv_high: cover property (load && src_q == sfl_pkg::SRC_NV && nvix_q == 2'h1);
endmodule

// [sfl_host.sv]
// Host serial controller model: select, serial clock and shared data lanes.
`timescale 1ns/10ps
module sfl_host (
   input wire logic clk_i,
   input wire logic [7:0] lane_i,
   output logic sel_b_o,
   output logic sclk_o,
   output logic [7:0] lane_o
);
   initial begin
      sel_b_o = 1'b1;
      sclk_o = 1'b0;
      lane_o = 8'h00;
   end
   // ----------------
   // Link cycles
   // ----------------
   // One 80 ns clock; a released lane toggles so a stale bit is never taken for data.
   task automatic clk(input logic d, input logic [3:0] a, b, output logic [7:0] r, f);
      f = lane_i;
      lane_o = d ? {a, a} : ~lane_o;
      #20 sclk_o = 1'b1;
      #20 r = lane_i;
      lane_o = d ? {b, b} : ~lane_o;
      #20 sclk_o = 1'b0;
      #20;
   endtask
   function automatic logic [15:0] sh(logic [15:0] s, logic [7:0] l, int w);
      logic [3:0] m;
      m = 4'((1 << w) - 1);
      return {8'(s[15:8] << w) | ((w == 1) ? {3'h0, l[5]} : l[7:4] & m),
              8'(s[7:0] << w) | ((w == 1) ? {3'h0, l[1]} : l[3:0] & m)};
   endfunction
   task automatic start();
      @(negedge clk_i);
      sel_b_o = 1'b0;
      #20;
   endtask
   task automatic stop();
      sel_b_o = 1'b1;
      #100;
   endtask
   task automatic send(input logic [31:0] v, input int n, w, input bit dtr);
      logic [7:0] r, f;
      logic [3:0] a, b;
      for (int i = n - w; i >= 0; i -= w) begin
         a = 4'(v >> i) & 4'((1 << w) - 1);
         b = ~a;
         if (dtr) begin
            i -= w;
            b = 4'(v >> i) & 4'((1 << w) - 1);
         end
         clk(1'b1, a, b, r, f);
      end
   endtask
   // At double rate the first bit follows the fall, so the sample before the first rise and the last rise sample are dropped.
   task automatic rd(input int w, input bit dtr, output logic [15:0] q);
      logic [7:0] r, f;
      int k;
      k = dtr ? 8 / (2 * w) + 1 : 8 / w;
      q = 16'h0000;
      for (int j = 1; j <= k; j++) begin
         clk(1'b0, 4'h0, 4'h0, r, f);
         if (dtr && j > 1) q = sh(q, f, w);
         if (!(dtr && j == k)) q = sh(q, r, w);
      end
   endtask
endmodule

// [sfl_top_tb.sv]
// Self-checking bench for the serial flash command front-end.
`timescale 1ns/10ps
module sfl_top_tb;
   logic sys_clk, rst_b, sel_b, sclk, dtr_en, prot_err, wel, clr;
   logic [7:0] h_lane, lane_w, lane_o, lane_oe, stat;
   logic [1:0] proto;
   logic [3:0] dum;
   logic [23:0] addr;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   int n_clr = 0;
   function automatic logic [15:0] mem(logic [23:0] a);
      return {a[7:0] ^ 8'hC3, a[7:0] + a[15:8]};
   endfunction
   function automatic logic [7:0] oev(int w);
      return (w == 1) ? 8'h22 : (w == 2) ? 8'h33 : 8'hFF;
   endfunction
   assign lane_w = (lane_oe & lane_o) | (~lane_oe & h_lane);
   sfl_top u_dut (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .CLK_EN_I(1'b1), .SEL_B_I(sel_b), .SCLK_I(sclk),
      .LANE_I(lane_w), .LANE_O(lane_o), .LANE_OE_O(lane_oe), .PROTO_I(proto), .DTR_EN_I(dtr_en),
      .DUMMY_CYC_I(dum), .PROT_ERR_I(prot_err), .STATUS_I(stat), .FLAG_I(8'h81), .NVCFG_I(16'hFE37),
      .VCFG_I(8'h5C), .EVCFG_I(8'hDF), .MEM_ADDR_O(addr), .MEM_DATA_I(mem(addr)), .WEL_O(wel), .CLR_FLAG_O(clr));
   sfl_host u_host (.clk_i(sys_clk), .lane_i(lane_w), .sel_b_o(sel_b), .sclk_o(sclk), .lane_o(h_lane));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      n_clr += int'(clr === 1'b1);
      if (cyc == 40000) begin
         mismatches++;
         complete_run();
      end
   end
   task automatic chk(input logic [15:0] s, e);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic complete_run();
      if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ----------------
   // Transfers
   // ----------------
   task automatic rd_op(input logic [7:0] op, input int cw, aw, dw, input bit dt, input int dn,
                        input logic [23:0] ad, input int nb, input logic [7:0] oe, output logic [15:0] q[$]);
      logic [7:0] r, f;
      logic [15:0] v;
      q = {};
      u_host.start();
      u_host.send(op, 8, cw, dtr_en);
      if (aw > 0) u_host.send(ad, 24, aw, dt);
      repeat (dn) u_host.clk(1'b0, 4'h0, 4'h0, r, f);
      chk(lane_oe, 8'h00);
      repeat (nb) begin
         u_host.rd(dw, dt, v);
         q.push_back(v);
      end
      chk(lane_oe, oe);
      u_host.stop();
      chk(lane_oe, 8'h00);
   endtask
   task automatic cmd(input logic [7:0] op, input int w, input bit late, input logic e, input int nc);
      logic [7:0] r, f;
      int c0;
      c0 = n_clr;
      proto = (w == 4) ? 2'h2 : (w == 2) ? 2'h1 : 2'h0;
      u_host.start();
      u_host.send(op, 8, w, 1'b0);
      if (late) u_host.clk(1'b0, 4'h0, 4'h0, r, f);
      u_host.stop();
      chk(wel, e);
      chk(16'(n_clr - c0), 16'(nc));
   endtask
   // ----------------
   // Scenarios
   // ----------------
   task automatic sc_latch();
      chk(wel, 1'b0);
      cmd(8'h06, 1, 1'b1, 1'b0, 0);
      cmd(8'h06, 4, 1'b0, 1'b1, 0);
      cmd(8'h04, 1, 1'b1, 1'b1, 0);
      cmd(8'h04, 2, 1'b0, 1'b0, 0);
      cmd(8'h06, 1, 1'b0, 1'b1, 0);
      prot_err = 1'b1;
      cmd(8'h04, 1, 1'b0, 1'b1, 0);
      cmd(8'h50, 1, 1'b0, 1'b0, 1);
      prot_err = 1'b0;
      proto = 2'h0;
   endtask
   task automatic sc_wrap();
      logic [15:0] q[$];
      rd_op(8'h03, 1, 1, 1, 1'b0, 0, 24'hFFFFFE, 3, 8'h22, q);
      for (int i = 0; i < 3; i++) chk(q[i], mem(24'hFFFFFE + 24'(i)));
   endtask
   task automatic sc_ops();
      logic [15:0] q[$];
      logic [7:0] ops[7] = '{8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hE7, 8'hE7};
      int aws[7] = '{1, 1, 2, 1, 4, 4, 4};
      int dws[7] = '{1, 2, 2, 4, 4, 4, 4};
      logic [23:0] ad;
      dum = 4'h3;
      for (int i = 0; i < 7; i++) begin
         proto = (i == 6) ? 2'h2 : 2'h0;
         ad = 24'h3A5C10 + 24'(2 * i) + 24'(i < 5);
         rd_op(ops[i], (i == 6) ? 4 : 1, aws[i], dws[i], 1'b0, (i > 4) ? 4 : 3, ad, 2, oev(dws[i]), q);
         for (int j = 0; j < 2; j++) chk(q[j], mem(ad + 24'(j)));
      end
      proto = 2'h0;
   endtask
   task automatic sc_dtr();
      logic [15:0] q[$];
      dum = 4'h2;
      rd_op(8'h0D, 1, 1, 1, 1'b1, 2, 24'h01F0E3, 1, 8'h22, q);
      chk(q[0], mem(24'h01F0E3));
      rd_op(8'hED, 1, 4, 4, 1'b1, 2, 24'h7FFF00, 1, 8'hFF, q);
      chk(q[0], mem(24'h7FFF00));
   endtask
   task automatic sc_refuse();
      logic [15:0] q[$];
      proto = 2'h1;
      rd_op(8'h0B, 2, 2, 2, 1'b0, 2, 24'h000101, 1, 8'h33, q);
      chk(q[0], mem(24'h000101));
      rd_op(8'hE7, 2, 2, 2, 1'b0, 4, 24'h000100, 1, 8'h00, q);
      proto = 2'h0;
      dtr_en = 1'b1;
      rd_op(8'hE7, 1, 4, 4, 1'b0, 4, 24'h000100, 1, 8'h00, q);
      dtr_en = 1'b0;
   endtask
   task automatic sc_regs();
      logic [15:0] q[$];
      logic [7:0] ops[4] = '{8'h05, 8'h70, 8'h85, 8'h65};
      logic [7:0] val[4];
      for (int p = 0; p < 3; p++) begin
         proto = 2'(p);
         stat = 8'hA3 ^ 8'(p);
         val = '{stat, 8'h81, 8'h5C, 8'hDF};
         for (int i = 0; i < 4; i++) begin
            rd_op(ops[i], 1 << p, 0, 1 << p, 1'b0, 0, 24'h0, 2, oev(1 << p), q);
            chk(q[0], {val[i], val[i]});
            chk(q[1], {val[i], val[i]});
         end
         rd_op(8'hB5, 1 << p, 0, 1 << p, 1'b0, 0, 24'h0, 3, oev(1 << p), q);
         chk(q[0], 16'h3737);
         chk(q[1], 16'hFEFE);
         chk(q[2], 16'h0000);
      end
   endtask
   initial begin
      rst_b = 1'b0;
      proto = 2'h0;
      dtr_en = 1'b0;
      dum = 4'h0;
      prot_err = 1'b0;
      stat = 8'hA3;
      repeat (16) @(negedge sys_clk);
      rst_b = 1'b1;
      sc_latch();
      sc_wrap();
      sc_ops();
      sc_dtr();
      sc_refuse();
      sc_regs();
      complete_run();
   end
endmodule
